// ==== verilog/aptp_pkg.sv ====
// Constants for the PWM trigger program register bank.
// Assumes a 32-bit APB slave on pclk with byte addresses.
package aptp_pkg;
   localparam int unsigned aptp_num_prog = 4;
   localparam int unsigned aptp_num_slot = 4;
   localparam int unsigned aptp_addr_w = 12;
   localparam logic [11:0] aptp_off_prog0 = 12'h000;
   localparam logic [11:0] aptp_off_prog1 = 12'h004;
   localparam logic [11:0] aptp_off_prog2 = 12'h008;
   localparam logic [11:0] aptp_off_prog3 = 12'h00c;
   localparam logic [11:0] aptp_off_isel0 = 12'h010;
   localparam logic [11:0] aptp_off_isel1 = 12'h014;
   localparam logic [11:0] aptp_off_isel2 = 12'h018;
   localparam logic [11:0] aptp_off_isel3 = 12'h01c;
   localparam int unsigned aptp_slot_w = 8;
   localparam int unsigned aptp_en_pos = 7;
   localparam int unsigned aptp_phase_lsb = 5;
   localparam int unsigned aptp_sel_lsb = 0;
   localparam logic [31:0] aptp_prog_reset = 32'h0000_0000;
   localparam logic [1:0] aptp_isel_reset = 2'h0;
   localparam logic [1:0] aptp_isel_none = 2'h0;
   localparam logic [1:0] aptp_isel_a = 2'h1;
   localparam logic [1:0] aptp_isel_b = 2'h2;
   localparam logic [1:0] aptp_phase_none = 2'h0;
   localparam logic [1:0] aptp_phase_u = 2'h1;
   localparam logic [1:0] aptp_phase_v = 2'h2;
   localparam logic [1:0] aptp_phase_w = 2'h3;
   localparam logic [4:0] aptp_max_code_first = 5'h0e;
   localparam logic [4:0] aptp_max_code_second = 5'h10;
endpackage

// ==== verilog/aptp_slot_decode.sv ====
// One trigger slot: splits a slot byte into its fields.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ns
module aptp_slot_decode
   import aptp_pkg::*;
#(
   parameter bit second_unit = 1'b0
) (
   input wire logic [7:0] slot_byte,
   output logic slot_enable,
   output logic [1:0] slot_phase_tag,
   output logic [4:0] slot_input_select,
   output logic slot_code_valid
);
   logic [4:0] max_code;

   always_comb begin
      max_code = second_unit ? aptp_max_code_second : aptp_max_code_first;
      slot_enable = slot_byte[aptp_en_pos]; // [RL1]
      slot_phase_tag = slot_byte[aptp_phase_lsb +: 2]; // [RL2]
      slot_input_select = slot_byte[aptp_sel_lsb +: 5]; // [RL3]
      // Reserved codes are stored as written; only flagged to the sequencer
      slot_code_valid = (slot_byte[aptp_sel_lsb +: 5] <= max_code); // [RL5]
   end
endmodule

// ==== verilog/aptp_regs.sv ====
// PWM trigger program register bank with APB slave and sequencer port.
// Assumes sequencer inputs come from logic on pclk; no synchronisers.
// Summary of operation
// [RL1] Bits 31,23,15,7 enable slots 3..0
// [RL2] Two-bit phase tag per slot: none,U,V,W
// [RL3] Five-bit input select per slot
// [RL4] Slot m result goes to register m
// [RL5] Binary codes; reserved codes above unit maximum
// [RL6] Per-program select raises done interrupt A/B
// [RL7] All fields reset zero, software read/write
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
module aptp_regs
   import aptp_pkg::*;
#(
   parameter bit second_unit = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] seq_prog_sel,
   input wire logic seq_done,
   output logic [3:0] slot_enable,
   output logic [7:0] slot_phase_tag,
   output logic [19:0] slot_input_select,
   output logic [7:0] conversion_result_slot,
   output logic [3:0] slot_code_valid,
   output logic pwm_seq_done_irq_a,
   output logic pwm_seq_done_irq_b
);
   typedef struct packed {
      logic [3:0][31:0] prog;
      logic [3:0][1:0] irq_sel;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic [3:0] en;
      logic [3:0][1:0] phase;
      logic [3:0][4:0] sel;
      logic [3:0][1:0] res_idx;
      logic [3:0] valid;
      logic irq_a;
      logic irq_b;
   } aptp_state_s;

   aptp_state_s cur;
   aptp_state_s next_cur;
   logic [3:0] dec_en;
   logic [3:0][1:0] dec_phase;
   logic [3:0][4:0] dec_sel;
   logic [3:0] dec_valid;
   logic [31:0] live_prog;

   assign live_prog = cur.prog[seq_prog_sel];

   // Slot m of the selected program always feeds result register m
   for (genvar m = 0; m < 4; m++) begin : g_slot
      aptp_slot_decode #(
         .second_unit(second_unit)
      ) u_dec (
         .slot_byte(live_prog[m*aptp_slot_w +: aptp_slot_w]),
         .slot_enable(dec_en[m]),
         .slot_phase_tag(dec_phase[m]),
         .slot_input_select(dec_sel[m]),
         .slot_code_valid(dec_valid[m])
      );
   end

   always_comb begin
      logic setup;
      logic wr;
      logic hit;
      logic [2:0] idx;
      logic [31:0] rd;
      logic [31:0] mask;
      setup = psel && !penable;
      wr = psel && penable && cur.ready && pwrite;
      hit = 1'b0;
      idx = 3'h0;
      rd = 32'h0000_0000;
      mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
      next_cur = cur;
      unique case (paddr)
         aptp_off_prog0: begin
            hit = 1'b1;
            idx = 3'h0;
         end
         aptp_off_prog1: begin
            hit = 1'b1;
            idx = 3'h1;
         end
         aptp_off_prog2: begin
            hit = 1'b1;
            idx = 3'h2;
         end
         aptp_off_prog3: begin
            hit = 1'b1;
            idx = 3'h3;
         end
         aptp_off_isel0: begin
            hit = 1'b1;
            idx = 3'h4;
         end
         aptp_off_isel1: begin
            hit = 1'b1;
            idx = 3'h5;
         end
         aptp_off_isel2: begin
            hit = 1'b1;
            idx = 3'h6;
         end
         aptp_off_isel3: begin
            hit = 1'b1;
            idx = 3'h7;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      if (hit && !idx[2]) begin
         rd = cur.prog[idx[1:0]]; // [RL7]
      end else if (hit) begin
         rd = {30'h0, cur.irq_sel[idx[1:0]]};
      end
      // Zero-wait slave: ready rises for the first access cycle only
      next_cur.ready = setup;
      if (setup) begin
         next_cur.rdata = pwrite ? 32'h0000_0000 : rd;
         next_cur.slverr = !hit;
      end
      if (wr && hit && !idx[2]) begin
         next_cur.prog[idx[1:0]] = (cur.prog[idx[1:0]] & ~mask) | (pwdata & mask); // [RL7]
      end
      if (wr && hit && idx[2] && pstrb[0]) begin
         next_cur.irq_sel[idx[1:0]] = pwdata[1:0]; // [RL6]
      end
      next_cur.en = dec_en; // [RL1]
      next_cur.phase = dec_phase; // [RL2]
      next_cur.sel = dec_sel; // [RL3]
      next_cur.valid = dec_valid; // [RL5]
      for (int m = 0; m < 4; m++) begin
         next_cur.res_idx[m] = 2'(m); // [RL4]
      end
      // Codes 00 and 11 raise nothing when the program finishes
      next_cur.irq_a = seq_done && (cur.irq_sel[seq_prog_sel] == aptp_isel_a); // [RL6]
      next_cur.irq_b = seq_done && (cur.irq_sel[seq_prog_sel] == aptp_isel_b); // [RL6]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0; // [RL7]
      end else begin
         cur <= next_cur;
      end
   end

   assign prdata = cur.rdata;
   assign pready = cur.ready;
   assign pslverr = cur.slverr;
   assign slot_enable = cur.en;
   assign slot_phase_tag = cur.phase;
   assign slot_input_select = cur.sel;
   assign conversion_result_slot = cur.res_idx;
   assign slot_code_valid = cur.valid;
   assign pwm_seq_done_irq_a = cur.irq_a;
   assign pwm_seq_done_irq_b = cur.irq_b;
endmodule

// ==== testbench/aptp_checker.sv ====
// Port assertions for the trigger program bank.
// Bound into aptp_regs; one pclk domain, presetn active low.
`timescale 1ns/1ns
module aptp_checker
   import aptp_pkg::*;
#(parameter bit second_unit = 1'b0) (
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic [11:0] paddr,
   input logic pready,
   input logic pslverr,
   input logic seq_done,
   input logic [19:0] slot_input_select,
   input logic [7:0] conversion_result_slot,
   input logic [3:0] slot_code_valid,
   input logic pwm_seq_done_irq_a,
   input logic pwm_seq_done_irq_b
);
   localparam logic [4:0] code_top = second_unit ? aptp_max_code_second : aptp_max_code_first;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   a_ready_next: assert property (s_setup |=> pready)
      else $error("no pready");
   a_ready_once: assert property (pready |=> !pready)
      else $error("long pready");
   a_unmapped_err: assert property (s_setup ##0 paddr > aptp_off_isel3 |=> pslverr)
      else $error("no pslverr");
   a_result_map: assert property (
      $past(presetn) |-> conversion_result_slot == 8'he4) else $error("result map");
   a_irq_excl: assert property (!(pwm_seq_done_irq_a && pwm_seq_done_irq_b))
      else $error("both irqs");
   a_irq_cause: assert property (
      (pwm_seq_done_irq_a || pwm_seq_done_irq_b) |-> $past(seq_done)) else $error("stray irq");
   a_code_valid: assert property (
      $past(presetn, 2) |-> slot_code_valid[3] == (slot_input_select[19:15] <= code_top))
      else $error("code valid");
endmodule
bind aptp_regs aptp_checker #(.second_unit(second_unit)) aptp_checker_inst (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .paddr(paddr),
   .pready(pready),
   .pslverr(pslverr),
   .seq_done(seq_done),
   .slot_input_select(slot_input_select),
   .conversion_result_slot(conversion_result_slot),
   .slot_code_valid(slot_code_valid),
   .pwm_seq_done_irq_a(pwm_seq_done_irq_a),
   .pwm_seq_done_irq_b(pwm_seq_done_irq_b)
);

// ==== testbench/aptp_seq_model.sv ====
// Sequencer and trigger source stand-in.
// Registers the bench's commands on pclk, like the real sequencer.
`timescale 1ns/1ns
module aptp_seq_model (
   input logic pclk,
   input logic presetn,
   input logic [1:0] prog,
   input logic fire,
   output logic [1:0] seq_prog_sel,
   output logic seq_done
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_prog_sel <= 2'h0;
         seq_done <= 1'b0;
      end else begin
         seq_prog_sel <= prog;
         seq_done <= fire;
      end
   end
endmodule

// ==== testbench/tb.sv ====
// Bench for aptp_regs: APB master, queued read checks.
// Assumes the first unit and full byte strobes.
`timescale 1ns/1ns
module tb;
   import aptp_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
   logic [11:0] paddr = 0;
   logic [3:0] pstrb = 4'hf, slot_enable, slot_code_valid, cv;
   logic [31:0] pwdata = 0, prdata, d;
   logic [1:0] prog = 0, seq_prog_sel;
   logic pready, pslverr, seq_done, pwm_seq_done_irq_a, pwm_seq_done_irq_b;
   logic [7:0] slot_phase_tag, conversion_result_slot;
   logic [19:0] slot_input_select;
   int bad_count = 0, samples_checked = 0, cycles = 0, seed = 32'h7b7e;
   logic [31:0] exp_q[$];
   always #20 pclk = ~pclk;
   aptp_regs aptp_regs_inst (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .seq_prog_sel(seq_prog_sel),
      .seq_done(seq_done),
      .slot_enable(slot_enable),
      .slot_phase_tag(slot_phase_tag),
      .slot_input_select(slot_input_select),
      .conversion_result_slot(conversion_result_slot),
      .slot_code_valid(slot_code_valid),
      .pwm_seq_done_irq_a(pwm_seq_done_irq_a),
      .pwm_seq_done_irq_b(pwm_seq_done_irq_b)
   );
   aptp_seq_model aptp_seq_model_inst (
      .pclk(pclk),
      .presetn(presetn),
      .prog(prog),
      .fire(fire),
      .seq_prog_sel(seq_prog_sel),
      .seq_done(seq_done)
   );
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(0, a, 0);
   endtask
   task automatic test_done();
      $display("checked %0d bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Reads are judged here, at the edge that completes them
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 2000) begin
         bad_count++;
         test_done();
      end else if (psel && penable && pready && !pwrite) begin
         chk(prdata, exp_q.pop_front());
      end
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      #1 chk({24'h0, conversion_result_slot}, 32'he4);
      @(posedge pclk);
      for (int i = 0; i < 9; i++) rd(12'(i * 4), 0);
      $display("reset and map done");
      for (int p = 0; p < 4; p++) begin
         d = $random(seed);
         xfer(1, 12'(p * 4), d);
         rd(12'(p * 4), d);
         prog <= 2'(p);
         repeat (3) @(posedge pclk);
         #1 chk({28'h0, slot_enable}, {28'h0, d[31], d[23], d[15], d[7]});
         chk({24'h0, slot_phase_tag}, {24'h0, d[30:29], d[22:21], d[14:13], d[6:5]});
         chk({12'h0, slot_input_select}, {12'h0, d[28:24], d[20:16], d[12:8], d[4:0]});
         for (int m = 0; m < 4; m++) cv[m] = (d[m * 8 +: 5] <= aptp_max_code_first);
         chk({28'h0, slot_code_valid}, {28'h0, cv});
         @(posedge pclk);
      end
      $display("slot fields done");
      prog <= 0;
      for (int s = 0; s < 4; s++) begin
         xfer(1, aptp_off_isel0, 32'(s));
         rd(aptp_off_isel0, 32'(s));
         fire <= 1;
         @(posedge pclk);
         fire <= 0;
         @(posedge pclk);
         #1 chk({30'h0, pwm_seq_done_irq_a, pwm_seq_done_irq_b}, {30'h0, s == 1, s == 2});
         @(posedge pclk);
      end
      $display("irq select done");
      test_done();
   end
endmodule
